// >>> design/stc_pkg.sv
// Shared constants, field layouts and carrier types of the
// sensor transceiver configuration register bank.
// Assumes a single 50 MHz device clock.
package stc_pkg;

    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS   = 24;
    localparam int CMD_BITS     = 8;
    localparam int DATA_W       = 16;
    localparam int ADDR_W       = 6;
    localparam int CMD_WRITE    = 7;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0]  ADDR_GEN_CFG    = 6'h01;
    localparam logic [5:0]  ADDR_CH_CTRL    = 6'h02;
    localparam logic [5:0]  ADDR_DIRECT_CMD = 6'h07;
    localparam logic [15:0] GEN_CFG_RESET   = 16'h8000;
    localparam logic [15:0] CH_CTRL_RESET   = 16'h0442;
    localparam logic [15:0] GEN_CFG_MASK    = 16'hFFDF;
    localparam logic [15:0] CH_CTRL_MASK    = 16'h077B;
    localparam logic [15:0] CMD_SETUP_PHASE_ONLY_DONE   = 16'h0001;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int GC_PAR       = 15;
    localparam int GC_MUX_OFF   = 14;
    localparam int GC_CH2_BUF   = 13;
    localparam int GC_CH2_SRC   = 11;
    localparam int GC_CH2_ENC   = 10;
    localparam int GC_CH1_BUF   = 9;
    localparam int GC_CH1_SRC   = 7;
    localparam int GC_CH1_ENC   = 6;
    localparam int GC_CLK       = 3;
    localparam int GC_SID       = 2;
    localparam int GC_CHK       = 1;
    localparam int GC_SUP       = 0;
    localparam int CC_REG_ON    = 10;
    localparam int CC_CH2_REQ   = 8;
    localparam int CC_CH2_ALLOW = 6;
    localparam int CC_CH2_ON    = 5;
    localparam int CC_CH1_REQ   = 3;
    localparam int CC_CH1_ALLOW = 1;
    localparam int CC_CH1_ON    = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 20;
    localparam int PARITY_PERIOD_NS = 150000;
    localparam int PARITY_CYCLES    = PARITY_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [2:0] PIN_RESET = 3'b010;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_PIN   = 2'b00,
        SRC_HOST  = 2'b01,
        SRC_AUTO  = 2'b10,
        SRC_PIN_B = 2'b11
    } stc_src_e;

    typedef enum logic [1:0] {
        CK_NONE = 2'b00,
        CK_1MHZ = 2'b01,
        CK_4MHZ = 2'b10
    } stc_clk_e;

    typedef enum logic [1:0] {
        PK_NONE   = 2'b00,
        PK_SHORT  = 2'b01,
        PK_LONG   = 2'b10,
        PK_BUFFER = 2'b11
    } stc_pulse_e;

    typedef enum logic [1:0] {
        ACC_WO = 2'b00,
        ACC_RO = 2'b01,
        ACC_RW = 2'b10,
        ACC_RC = 2'b11
    } stc_acc_e;

    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_CMD  = 2'b01,
        SP_DATA = 2'b10,
        SP_DONE = 2'b11
    } stc_spi_e;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } stc_spi_in_s;

    typedef struct packed {
        logic       valid;
        stc_pulse_e kind;
    } stc_pulse_s;

    typedef struct packed {
        logic     address_muxing_off;
        logic     ch2_buffer_sets_pulse_length;
        stc_src_e ch2_sync_source;
        logic     ch2_sync_encoding;
        logic     ch1_buffer_sets_pulse_length;
        stc_src_e ch1_sync_source;
        logic     ch1_sync_encoding;
        stc_clk_e ext_clock_select;
        logic     sensor_id_flag_use;
        logic     check_bits_source;
        logic     supply_level_select;
        logic     supply_regulator_on;
        logic     ch2_pulse_allow;
        logic     ch2_power_on;
        logic     ch1_pulse_allow;
        logic     ch1_power_on;
    } stc_cfg_s;

endpackage

// >>> design/stc_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/10ps
module stc_pin_sync #(
    parameter int            W         = 3,
    parameter logic [W-1:0]  RESET_VAL = '0
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // ------------------------------------------------------------
    // Stages and filter
    // ------------------------------------------------------------
    // Stage one feeds only stage two; the filter looks at two and three
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            q    <= RESET_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    q[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

// >>> design/stc_tick.sv
// Free-running divider giving a one-cycle enable every PERIOD clocks.
// Assumes PERIOD of at least two.
`timescale 1ns/10ps
module stc_tick #(
    parameter int PERIOD = 7500
) (
    input  wire logic mclk,
    input  wire logic rst,
    output logic      tick_q
);

    localparam int CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_q;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (cnt_q == LAST);
            if (cnt_q == LAST) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule

// >>> design/stc_config_regs.sv
// Configuration register bank of a two-channel sensor transceiver,
// reached over a serial mode-0 link (24-bit frames, MSB first).
// Assumes host clock slow enough for triple-flop pin sampling.
//
// Function
// - Setup-phase registers accept writes only until the programming-done command.
// - Every 150 us recheck parity; flag global fault on any error.
// - Four access types: write-only, read-only, read/write, read-to-clear; no address here is given read-to-clear.
// - General config bit 15 is odd check bit; resets to one.
// - Bit 14 turns address multiplexing off when set; resets to zero.
// - Bit 13 lets channel 2 buffer set pulse length; forced under auto.
// - Bits 12:11 pick channel 2 source: pin, host command, automatic.
// - Bit 10 picks channel 2 encoding, effective only with buffer length.
// - Bit 9 is channel 1 buffer length, forced under automatic generation.
// - Bits 8:7 channel 1 source, bit 6 encoding when bit 9 set.
// - Bits 4:3 select external clock: none, 1MHz or 4MHz.
// - Bit 2 enables sensor identifier and global bit use.
// - Bit 1 chooses sensor check bits or transceiver-computed ones.
// - Bit 0 picks regulator output level, 5.3 V or 7.6 V.
// - Channel control bit 10 switches regulator; resets to one.
// - Bits 9:8 request channel 2 host pulse: none, short, long.
// - Bits 4:3 request channel 1 host pulse with same coding.
// - Request ignored while channel off; evaluated once right after write.
// - Under buffer control short and long act alike; buffer gives length.
// - Bits 6 and 1 allow sync pulses; reset to one.
// - Bits 5 and 0 power channels 2 and 1; reset zero.
`timescale 1ns/10ps
module stc_config_regs
    import stc_pkg::*;
#(
    parameter int CHECK_CYCLES = stc_pkg::PARITY_CYCLES
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 sclk,
    input  wire logic                 cs_n,
    input  wire logic                 mosi,
    output logic                      miso_q,
    output stc_pkg::stc_cfg_s         cfg_q,
    output stc_pkg::stc_pulse_s       ch1_pulse_q,
    output stc_pkg::stc_pulse_s       ch2_pulse_q,
    output logic                      setup_locked_q,
    output logic                      global_fault_q
);
    import stc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        stc_spi_e              st;
        logic [4:0]            bit_cnt;
        logic [FRAME_BITS-1:0] rx;
        logic [DATA_W-1:0]     tx;
        logic                  miso;
        logic                  sclk_prev;
        logic [DATA_W-1:0]     gen_cfg;
        logic [DATA_W-1:0]     ch_ctrl;
        logic                  locked;
        logic                  fault;
        stc_pulse_s            ch1_pulse;
        stc_pulse_s            ch2_pulse;
        stc_cfg_s              cfg;
    } stc_state_s;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Automatic generation always hands pulse length to the buffer
    function automatic logic buf_eff(input logic bit_v, input logic [1:0] src);
        buf_eff = bit_v | (src == SRC_AUTO);
    endfunction

    function automatic stc_pulse_e pulse_kind(input logic [1:0] req, input logic buf_on);
        if (req == PK_SHORT || req == PK_LONG) begin
            pulse_kind = buf_on ? PK_BUFFER : stc_pulse_e'(req);
        end else begin
            pulse_kind = PK_NONE;
        end
    endfunction

    function automatic stc_clk_e clk_sel(input logic [1:0] f);
        clk_sel = (f == 2'b11) ? CK_NONE : stc_clk_e'(f);
    endfunction

    function automatic stc_cfg_s decode(input logic [15:0] g, input logic [15:0] c);
        stc_cfg_s r;
        logic     b1;
        logic     b2;
        r  = '0;
        b2 = buf_eff(g[GC_CH2_BUF], g[GC_CH2_SRC+:2]);
        b1 = buf_eff(g[GC_CH1_BUF], g[GC_CH1_SRC+:2]);
        r.address_muxing_off           = g[GC_MUX_OFF];
        r.ch2_buffer_sets_pulse_length = b2;
        r.ch2_sync_source              = stc_src_e'(g[GC_CH2_SRC+:2]);
        r.ch2_sync_encoding            = g[GC_CH2_ENC] & b2;
        r.ch1_buffer_sets_pulse_length = b1;
        r.ch1_sync_source              = stc_src_e'(g[GC_CH1_SRC+:2]);
        r.ch1_sync_encoding            = g[GC_CH1_ENC] & b1;
        r.ext_clock_select             = clk_sel(g[GC_CLK+:2]);
        r.sensor_id_flag_use           = g[GC_SID];
        r.check_bits_source            = g[GC_CHK];
        r.supply_level_select          = g[GC_SUP];
        r.supply_regulator_on          = c[CC_REG_ON];
        r.ch2_pulse_allow              = c[CC_CH2_ALLOW];
        r.ch2_power_on                 = c[CC_CH2_ON];
        r.ch1_pulse_allow              = c[CC_CH1_ALLOW];
        r.ch1_power_on                 = c[CC_CH1_ON];
        decode = r;
    endfunction

    function automatic stc_acc_e access_of(input logic [5:0] a);
        case (a)
            ADDR_GEN_CFG:    access_of = ACC_RW;
            ADDR_CH_CTRL:    access_of = ACC_RW;
            ADDR_DIRECT_CMD: access_of = ACC_WO;
            default:         access_of = ACC_RO;
        endcase
    endfunction

    // One channel request, only on power-on and with pulses allowed
    function automatic stc_pulse_s host_pulse(input logic on, input logic allow,
                                              input logic [1:0] req, input logic buf_on);
        stc_pulse_s p;
        p.kind  = pulse_kind(req, buf_on);
        p.valid = on & allow & (p.kind != PK_NONE);
        if (!p.valid) begin
            p.kind = PK_NONE;
        end
        host_pulse = p;
    endfunction

    localparam stc_state_s ST_RESET = '{
        st:        SP_IDLE,
        bit_cnt:   5'h00,
        rx:        24'h000000,
        tx:        16'h0000,
        miso:      1'b0,
        sclk_prev: 1'b0,
        gen_cfg:   GEN_CFG_RESET,
        ch_ctrl:   CH_CTRL_RESET,
        locked:    1'b0,
        fault:     1'b0,
        ch1_pulse: '{valid: 1'b0, kind: PK_NONE},
        ch2_pulse: '{valid: 1'b0, kind: PK_NONE},
        cfg:       decode(GEN_CFG_RESET, CH_CTRL_RESET)
    };

    // ------------------------------------------------------------
    // Pin sampling and check period
    // ------------------------------------------------------------
    stc_spi_in_s pins;
    logic        check_tick;
    stc_state_s  s_q;
    stc_state_s  s_d;

    stc_pin_sync #(
        .W         (3),
        .RESET_VAL (PIN_RESET)
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    ({sclk, cs_n, mosi}),
        .q    (pins)
    );

    stc_tick #(
        .PERIOD (CHECK_CYCLES)
    ) u_tick (
        .mclk   (mclk),
        .rst    (rst),
        .tick_q (check_tick)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [FRAME_BITS-1:0] rx_n;
        logic [5:0]            addr;
        logic [15:0]           wdata;
        logic                  rise;
        logic                  fall;
        rx_n  = '0;
        addr  = '0;
        wdata = '0;
        s_d   = s_q;
        rise  = pins.sclk & ~s_q.sclk_prev;
        fall  = ~pins.sclk & s_q.sclk_prev;
        s_d.sclk_prev = pins.sclk;
        s_d.ch1_pulse = '{valid: 1'b0, kind: PK_NONE};
        s_d.ch2_pulse = '{valid: 1'b0, kind: PK_NONE};

        if (pins.cs_n) begin
            s_d.st      = SP_IDLE;
            s_d.bit_cnt = '0;
            s_d.miso    = 1'b0;
        end else begin
            case (s_q.st)
                SP_IDLE: begin
                    s_d.st = SP_CMD;
                end
                SP_CMD, SP_DATA: begin
                    if (rise) begin
                        rx_n        = {s_q.rx[FRAME_BITS-2:0], pins.mosi};
                        s_d.rx      = rx_n;
                        s_d.bit_cnt = s_q.bit_cnt + 5'd1;
                        if (s_q.bit_cnt == 5'(CMD_BITS - 1)) begin
                            // Unreadable and unmapped words return zero
                            addr   = rx_n[ADDR_W-1:0];
                            s_d.st = SP_DATA;
                            s_d.tx = '0;
                            if (access_of(addr) == ACC_RW) begin
                                if (addr == ADDR_GEN_CFG) begin
                                    s_d.tx = s_q.gen_cfg;
                                end else begin
                                    s_d.tx = s_q.ch_ctrl;
                                end
                            end
                        end
                        if (s_q.bit_cnt == 5'(FRAME_BITS - 1)) begin
                            s_d.st = SP_DONE;
                            addr   = rx_n[DATA_W+:ADDR_W];
                            wdata  = rx_n[DATA_W-1:0];
                            if (rx_n[DATA_W+CMD_WRITE]) begin
                                case (addr)
                                    ADDR_GEN_CFG: begin
                                        if (!s_q.locked) begin
                                            s_d.gen_cfg = wdata & GEN_CFG_MASK;
                                        end
                                    end
                                    ADDR_CH_CTRL: begin
                                        s_d.ch_ctrl   = wdata & CH_CTRL_MASK;
                                        s_d.ch1_pulse = host_pulse(wdata[CC_CH1_ON], wdata[CC_CH1_ALLOW],
                                                                   wdata[CC_CH1_REQ+:2],
                                                                   s_q.cfg.ch1_buffer_sets_pulse_length);
                                        s_d.ch2_pulse = host_pulse(wdata[CC_CH2_ON], wdata[CC_CH2_ALLOW],
                                                                   wdata[CC_CH2_REQ+:2],
                                                                   s_q.cfg.ch2_buffer_sets_pulse_length);
                                    end
                                    ADDR_DIRECT_CMD: begin
                                        if (wdata == CMD_SETUP_PHASE_ONLY_DONE) begin
                                            s_d.locked = 1'b1;
                                        end
                                    end
                                    default: begin
                                        s_d.locked = s_q.locked;
                                    end
                                endcase
                            end
                        end
                    end
                    // Data leaves on falling edges so the host samples on rising
                    if (fall && s_q.st == SP_DATA) begin
                        s_d.miso = s_q.tx[DATA_W-1];
                        s_d.tx   = {s_q.tx[DATA_W-2:0], 1'b0};
                    end
                end
                SP_DONE: begin
                    // Extra clocks past a full frame are ignored
                    s_d.miso = 1'b0;
                end
                default: begin
                    s_d.st = SP_IDLE;
                end
            endcase
        end

        // Level reflects the most recent check, not sticky
        if (check_tick) begin
            s_d.fault = ~(^s_q.gen_cfg);
        end

        s_d.cfg = decode(s_d.gen_cfg, s_d.ch_ctrl);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= ST_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign miso_q         = s_q.miso;
    assign cfg_q          = s_q.cfg;
    assign ch1_pulse_q    = s_q.ch1_pulse;
    assign ch2_pulse_q    = s_q.ch2_pulse;
    assign setup_locked_q = s_q.locked;
    assign global_fault_q = s_q.fault;

endmodule

// >>> test/stc_host.sv
// Serial master model standing in for the microcontroller.
// Assumes mclk at 50 MHz; the bench calls xfer once per frame.
`timescale 1ns/10ps
module stc_host (
    input  wire logic mclk,
    input  wire logic miso_q,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // --------------------------------
    // Mode 0 frame, MSB first, 24 bits
    // --------------------------------
    // Half period of 8 mclk leaves miso settled before each rise
    task automatic xfer(input logic [23:0] f, output logic [15:0] rd);
        rd = 16'h0000;
        @(negedge mclk);
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            repeat (8) @(negedge mclk);
            sclk = 1'b0;
            mosi = f[i];
            repeat (8) @(negedge mclk);
            if (i < 16)
                rd[i] = miso_q;
            sclk = 1'b1;
        end
        repeat (8) @(negedge mclk);
        sclk = 1'b0;
        repeat (4) @(negedge mclk);
        cs_n = 1'b1;
        // Released line must not keep showing the last bit
        mosi = ~mosi;
        repeat (12) @(negedge mclk);
    endtask
endmodule

// >>> test/stc_chk.sv
// Port-level assertions for the configuration register bank.
// Assumes one mclk domain with active-high reset.
`timescale 1ns/10ps
module stc_chk #(
    parameter int CHECK_CYCLES = 20
) (
    input wire logic                mclk,
    input wire logic                rst,
    input wire logic                cs_n,
    input wire logic                miso_q,
    input wire stc_pkg::stc_cfg_s   cfg_q,
    input wire stc_pkg::stc_pulse_s ch1_pulse_q,
    input wire stc_pkg::stc_pulse_s ch2_pulse_q,
    input wire logic                setup_locked_q,
    input wire logic                global_fault_q
);
    import stc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    AST_P1_LEN: assert property (ch1_pulse_q.valid |=> !ch1_pulse_q.valid)
        else $error("ch1 pulse longer than one cycle");
    AST_P2_LEN: assert property (ch2_pulse_q.valid |=> !ch2_pulse_q.valid)
        else $error("ch2 pulse longer than one cycle");
    AST_P1_GATE: assert property (ch1_pulse_q.valid |-> cfg_q.ch1_power_on && cfg_q.ch1_pulse_allow
        && ch1_pulse_q.kind != PK_NONE) else $error("ch1 pulse while blocked");
    AST_P2_GATE: assert property (ch2_pulse_q.valid |-> cfg_q.ch2_power_on && cfg_q.ch2_pulse_allow
        && ch2_pulse_q.kind != PK_NONE) else $error("ch2 pulse while blocked");
    AST_P1_BUF: assert property (ch1_pulse_q.valid |->
        (ch1_pulse_q.kind == PK_BUFFER) == cfg_q.ch1_buffer_sets_pulse_length) else $error("ch1 pulse kind");
    AST_AUTO1: assert property (cfg_q.ch1_sync_source == SRC_AUTO |-> cfg_q.ch1_buffer_sets_pulse_length)
        else $error("ch1 auto without buffer length");
    AST_AUTO2: assert property (cfg_q.ch2_sync_source == SRC_AUTO |-> cfg_q.ch2_buffer_sets_pulse_length)
        else $error("ch2 auto without buffer length");
    AST_ENC: assert property (cfg_q.ch1_sync_encoding |-> cfg_q.ch1_buffer_sets_pulse_length)
        else $error("ch1 encoding without buffer length");
    AST_CLK: assert property (cfg_q.ext_clock_select != 2'b11)
        else $error("clock select not mapped");
    AST_LOCK_KEEP: assert property (setup_locked_q |=> setup_locked_q)
        else $error("lock dropped");
    AST_LOCK_CFG: assert property (setup_locked_q && $past(setup_locked_q) |->
        $stable(cfg_q.ch2_sync_source) && $stable(cfg_q.ext_clock_select)) else $error("locked config moved");
    AST_MISO_IDLE: assert property (cs_n [*8] |-> !miso_q)
        else $error("miso active while deselected");
    AST_FAULT_HOLD: assert property ($changed(global_fault_q) |=> $stable(global_fault_q) [*8])
        else $error("fault changed between checks");
endmodule

// >>> test/tb.sv
// Self-checking bench for the configuration register bank.
// Assumes stc_host drives the serial pins; stc_chk is bound in below.
`timescale 1ns/10ps
module tb;
    import stc_pkg::*;
    typedef struct packed {
        logic [5:0]  a;
        logic [15:0] d;
        stc_clk_e    ck;
        stc_pulse_e  k1;
        stc_pulse_e  k2;
    } stc_row_s;
    logic        mclk;
    logic        rst;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic        miso_q;
    logic        setup_locked_q;
    logic        global_fault_q;
    stc_cfg_s    cfg_q;
    stc_pulse_s  ch1_pulse_q;
    stc_pulse_s  ch2_pulse_q;
    stc_pulse_e  seen1;
    stc_pulse_e  seen2;
    logic [15:0] rd;
    logic [15:0] d;
    int          err_count;
    int          check_count;
    stc_row_s    rows [12];

    stc_config_regs #(.CHECK_CYCLES(20)) i_stc_config_regs (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .miso_q(miso_q), .cfg_q(cfg_q), .ch1_pulse_q(ch1_pulse_q), .ch2_pulse_q(ch2_pulse_q),
        .setup_locked_q(setup_locked_q), .global_fault_q(global_fault_q));
    stc_host i_stc_host (.mclk(mclk), .miso_q(miso_q), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (ch1_pulse_q.valid === 1'b1)
            seen1 <= ch1_pulse_q.kind;
        if (ch2_pulse_q.valid === 1'b1)
            seen2 <= ch2_pulse_q.kind;
    end

    // ----------------
    // Helpers
    // ----------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        chk(n, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        i_stc_host.xfer({2'b10, a, v}, rd);
    endtask
    task automatic rdr(input logic [5:0] a);
        i_stc_host.xfer({2'b00, a, 16'h0000}, rd);
    endtask
    // Odd parity across all 16 bits
    function automatic logic [15:0] par(input logic [15:0] v);
        return {~^v[14:0], v[14:0]};
    endfunction
    task automatic wait_fault(input logic v);
        for (int n = 0; n < 100 && global_fault_q !== v; n++)
            @(negedge mclk);
        chk_bit("global fault", v, global_fault_q);
        if (global_fault_q !== v)
            print_verdict();
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        rst = 1'b1;
        err_count = 0;
        check_count = 0;
        seen1 = PK_NONE;
        seen2 = PK_NONE;
        rows = '{'{ADDR_GEN_CFG, 16'h0038, CK_NONE, PK_NONE, PK_NONE}, '{ADDR_GEN_CFG, 16'h0008, CK_1MHZ, PK_NONE, PK_NONE},
            '{ADDR_GEN_CFG, 16'h4010, CK_4MHZ, PK_NONE, PK_NONE}, '{ADDR_CH_CTRL, 16'h002B, CK_4MHZ, PK_SHORT, PK_NONE},
            '{ADDR_CH_CTRL, 16'h0013, CK_4MHZ, PK_LONG, PK_NONE}, '{ADDR_CH_CTRL, 16'h001B, CK_4MHZ, PK_NONE, PK_NONE},
            '{ADDR_CH_CTRL, 16'h000A, CK_4MHZ, PK_NONE, PK_NONE}, '{ADDR_CH_CTRL, 16'h0009, CK_4MHZ, PK_NONE, PK_NONE},
            '{ADDR_CH_CTRL, 16'h0160, CK_4MHZ, PK_NONE, PK_SHORT}, '{ADDR_CH_CTRL, 16'h0260, CK_4MHZ, PK_NONE, PK_LONG},
            '{ADDR_GEN_CFG, 16'h3140, CK_NONE, PK_NONE, PK_NONE}, '{ADDR_CH_CTRL, 16'h016B, CK_NONE, PK_BUFFER, PK_BUFFER}};
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        repeat (6) @(negedge mclk);
        foreach (rows[i]) begin
            d = (rows[i].a == ADDR_GEN_CFG) ? par(rows[i].d) : rows[i].d;
            seen1 = PK_NONE;
            seen2 = PK_NONE;
            wr(rows[i].a, d);
            chk("ch1 pulse", {14'h0000, rows[i].k1}, {14'h0000, seen1});
            chk("ch2 pulse", {14'h0000, rows[i].k2}, {14'h0000, seen2});
            chk("clock select", {14'h0000, rows[i].ck}, {14'h0000, cfg_q.ext_clock_select});
            rdr(rows[i].a);
            chk("readback", d & ((rows[i].a == ADDR_GEN_CFG) ? GEN_CFG_MASK : CH_CTRL_MASK), rd);
        end
        chk_bit("ch1 encoding", 1'b1, cfg_q.ch1_sync_encoding);
        $display("test table done");
        wr(6'h3F, 16'hFFFF);
        rdr(6'h3F);
        chk("unmapped", 16'h0000, rd);
        $display("test unmapped done");
        wait_fault(1'b0);
        wr(ADDR_GEN_CFG, 16'h0003);
        wait_fault(1'b1);
        wr(ADDR_GEN_CFG, par(16'h0003));
        wait_fault(1'b0);
        $display("test parity done");
        wr(ADDR_DIRECT_CMD, CMD_SETUP_PHASE_ONLY_DONE);
        chk_bit("locked", 1'b1, setup_locked_q);
        wr(ADDR_GEN_CFG, par(16'h0008));
        rdr(ADDR_GEN_CFG);
        chk("locked general", 16'h8003, rd);
        wr(ADDR_CH_CTRL, 16'h0402);
        rdr(ADDR_CH_CTRL);
        chk("channel after lock", 16'h0402, rd);
        $display("test lock done");
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        repeat (6) @(negedge mclk);
        chk_bit("locked", 1'b0, setup_locked_q);
        chk_bit("regulator on", 1'b1, cfg_q.supply_regulator_on);
        rdr(ADDR_GEN_CFG);
        chk("general reset", 16'h8000, rd);
        rdr(ADDR_CH_CTRL);
        chk("channel reset", 16'h0442, rd);
        wr(ADDR_GEN_CFG, par(16'h0001));
        chk_bit("supply level", 1'b1, cfg_q.supply_level_select);
        $display("test reset done");
        print_verdict();
    end
endmodule

bind stc_config_regs stc_chk #(.CHECK_CYCLES(CHECK_CYCLES)) i_stc_chk (.mclk(mclk), .rst(rst), .cs_n(cs_n),
    .miso_q(miso_q), .cfg_q(cfg_q), .ch1_pulse_q(ch1_pulse_q), .ch2_pulse_q(ch2_pulse_q),
    .setup_locked_q(setup_locked_q), .global_fault_q(global_fault_q));
